// file: verilog/capseq_cfg.svh
/*
 * Register offsets, field positions and reset values of the capture
 * sequencing and interrupt-enable block.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef CAPSEQ_CFG_SVH
`define CAPSEQ_CFG_SVH

// ************************************************************
// Register byte offsets on the APB
// ************************************************************
`define OFF_CTL2 12'h000
`define OFF_IRQ_EN 12'h004
`define OFF_FLAGS 12'h008
`define OFF_CLEAR 12'h00c
`define OFF_FORCE 12'h010
`define OFF_COUNTER 12'h014
`define OFF_TS0 12'h020
`define TS_BLOCK_MASK 12'hff0

// ************************************************************
// Field positions
// ************************************************************
`define CTL2_SINGLE 0
`define CTL2_LIMIT_LO 1
`define CTL2_LIMIT_HI 2
`define CTL2_ARM 3
`define CTL2_RUN 4
`define CTL2_PWM 9
`define FLG_INT 0
`define FLG_OVF 5
`define FLG_PRD 6
`define FLG_CMP 7
`define IRQ_EN_MASK 8'hfe

// ************************************************************
// Reset values
// ************************************************************
`define RST_LIMIT 2'h3
`define RST_SINGLE 1'h0
`define RST_IRQ_EN 8'h00

`endif

// file: verilog/capseq_pkg.sv
/*
 * Types shared by the capture sequencing block: sequencer state and the
 * packed state records of each module.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package capseq_pkg;

   // Sequencer run state
   typedef enum logic [0:0] {
      SEQ_RUN = 1'b0,
      SEQ_STOP = 1'b1
   } seq_state_t;

   typedef struct packed {
      seq_state_t st;
      logic [1:0] idx;
      logic load_en;
   } seq_regs_t;

   typedef struct packed {
      logic [7:0] flags;
   } flag_regs_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic pin_prev;
      logic single;
      logic [1:0] limit;
      logic run;
      logic pwm;
      logic [7:0] irq_en;
      logic [31:0] counter;
      logic [3:0][31:0] ts;
      logic [31:0] prdata;
      logic ready;
      logic err;
   } top_regs_t;

endpackage : capseq_pkg

// file: verilog/ctl_if.sv
/*
 * Interface joining the register/timestamp hub to the sequencer and the
 * flag unit.
 * Assumes all three sit on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface ctl_if;
   logic cap_event;
   logic arm;
   logic single_mode;
   logic pwm_mode;
   logic [1:0] limit;
   logic [1:0] idx;
   logic stopped;
   logic load_en;
   logic load_strobe;
   logic [3:0] cevt;
   logic [2:0] ev_hi;
   logic [7:0] irq_en;
   logic [7:0] clr;
   logic [7:0] frc;
   logic [7:0] flags;
   logic irq;

   modport seq (input cap_event, arm, single_mode, pwm_mode, limit,
                output idx, stopped, load_en, load_strobe, cevt);
   modport flg (input cevt, ev_hi, irq_en, clr, frc, output flags, irq);
endinterface : ctl_if

`default_nettype wire

// file: verilog/capture_sequencer.sv
/*
 * Event index counter with one-shot stop and continuous wrap.
 * Assumes cap_event is a one-cycle pulse on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module capture_sequencer (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   ctl_if.seq s
);
   capseq_pkg::seq_regs_t r_ff;
   capseq_pkg::seq_regs_t nxt_r;
   logic acc;
   logic single_eff;

   function automatic logic [3:0] onehot(input logic [1:0] i);
      onehot = 4'h1 << i;
   endfunction : onehot

   // Single-sequence only means something in capture mode
   assign single_eff = s.single_mode & ~s.pwm_mode;
   // No capture events in PWM mode, none once stopped
   assign acc = s.cap_event & ~s.pwm_mode & (r_ff.st == capseq_pkg::SEQ_RUN);
   assign s.cevt = acc ? onehot(r_ff.idx) : 4'h0;
   assign s.load_strobe = acc & r_ff.load_en & ~s.pwm_mode;
   assign s.idx = r_ff.idx;
   assign s.stopped = (r_ff.st == capseq_pkg::SEQ_STOP);
   assign s.load_en = r_ff.load_en;

   // Next state of the index counter
   always_comb begin
      nxt_r = r_ff;
      case (r_ff.st)
         capseq_pkg::SEQ_RUN: begin
            if (acc && single_eff && r_ff.idx == s.limit) begin
               nxt_r.st = capseq_pkg::SEQ_STOP;
               nxt_r.load_en = 1'b0;
            end else if (acc) begin
               nxt_r.idx = (r_ff.idx == s.limit) ? 2'h0 : r_ff.idx + 2'h1;
            end
         end
         capseq_pkg::SEQ_STOP: begin
            nxt_r.st = capseq_pkg::SEQ_STOP;
         end
         default: nxt_r.st = capseq_pkg::SEQ_STOP;
      endcase
      // Arm wins over an event in the same cycle, in either mode
      if (s.arm) begin
         nxt_r.idx = 2'h0;
         nxt_r.st = capseq_pkg::SEQ_RUN;
         nxt_r.load_en = 1'b1;
      end
   end

   // State register, frozen while ce is low
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_ff <= '{st: capseq_pkg::SEQ_RUN, idx: 2'h0, load_en: 1'b1};
      end else if (ce) begin
         r_ff <= nxt_r;
      end
   end

   a_arm_restarts: assert property (@(posedge clk) disable iff (!resetn)
      ce && s.arm |=> s.idx == 2'h0 && !s.stopped && s.load_en)
      else $error("arm did not restart the sequence");
   a_single_stop: assert property (@(posedge clk) disable iff (!resetn)
      ce && acc && single_eff && s.idx == s.limit && !s.arm |=> s.stopped && !s.load_en)
      else $error("single sequence did not stop at limit");
   a_cont_wrap: assert property (@(posedge clk) disable iff (!resetn)
      ce && acc && !single_eff && s.idx == s.limit && !s.arm |=> s.idx == 2'h0 && !s.stopped)
      else $error("continuous sequence did not wrap");
   a_stopped_quiet: assert property (@(posedge clk) disable iff (!resetn)
      s.stopped |-> s.cevt == 4'h0 && !s.load_strobe)
      else $error("event passed while stopped");
   a_pwm_no_load: assert property (@(posedge clk) disable iff (!resetn)
      s.pwm_mode |-> !s.load_strobe)
      else $error("timestamp load in PWM mode");
endmodule : capture_sequencer

`default_nettype wire

// file: verilog/flag_unit.sv
/*
 * Event flags, global interrupt flag and interrupt gating.
 * Assumes clear and force are one-cycle pulse vectors on clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "capseq_cfg.svh"

module flag_unit (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   ctl_if.flg f
);
   capseq_pkg::flag_regs_t r_ff;
   capseq_pkg::flag_regs_t nxt_r;
   logic [7:1] set_v;
   logic pend;

   assign f.flags = r_ff.flags;
   assign f.irq = r_ff.flags[`FLG_INT];

   // Flags latch regardless of enables; a set beats a same-cycle clear
   always_comb begin
      nxt_r = r_ff;
      set_v = {f.ev_hi, f.cevt} | f.frc[7:1];
      pend = |(r_ff.flags[7:1] & f.irq_en[7:1]);
      nxt_r.flags[7:1] = (r_ff.flags[7:1] & ~f.clr[7:1]) | set_v;
      // Clearing the global flag re-raises it next cycle if work remains
      nxt_r.flags[`FLG_INT] = (r_ff.flags[`FLG_INT] & ~f.clr[`FLG_INT])
         | (pend & ~r_ff.flags[`FLG_INT]) | f.frc[`FLG_INT];
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_ff <= '{flags: 8'h00};
      end else if (ce) begin
         r_ff <= nxt_r;
      end
   end

   a_event_sets: assert property (@(posedge clk) disable iff (!resetn)
      ce && f.cevt[0] |=> f.flags[1])
      else $error("capture event 1 did not set its flag");
   a_clear_flag: assert property (@(posedge clk) disable iff (!resetn)
      ce && f.clr[`FLG_CMP] && !f.ev_hi[2] && !f.frc[`FLG_CMP] |=> !f.flags[`FLG_CMP])
      else $error("clear did not drop compare flag");
   a_irq_gated: assert property (@(posedge clk) disable iff (!resetn)
      !f.irq && (f.flags[7:1] & f.irq_en[7:1]) == 7'h00 && !f.frc[0] |=> !f.irq)
      else $error("interrupt from a disabled source");
   a_irq_raise: assert property (@(posedge clk) disable iff (!resetn)
      ce && !f.irq && (f.flags[7:1] & f.irq_en[7:1]) != 7'h00 |=> f.irq)
      else $error("enabled flag did not raise interrupt");
   a_int_clear: assert property (@(posedge clk) disable iff (!resetn)
      ce && f.irq && f.clr[0] && !f.frc[0] |=> !f.irq)
      else $error("global flag clear ignored");
endmodule : flag_unit

`default_nettype wire

// file: verilog/capture_sequence_irq_ctl.sv
/*
 * Top of the capture sequencing and interrupt-enable block: APB register
 * slave, pin synchroniser, timestamp counter and the four timestamp
 * registers; sequencing and flags live in two sub-modules.
 * APB transfers answer in their first access cycle unless ce is low;
 * read data are taken in the setup cycle, so a flag that sets during
 * the access shows only on the next read.
 * The capture pin passes two flip-flops before the edge detector, so
 * an edge reaches the edge detector two clocks late and a pulse under
 * one clock long may be missed.
 * The counter counts only while its run bit is set; with ce low the
 * whole block, synchroniser included, holds still.
 * Assumes a single 40 MHz clock, synchronous active-low reset, and that
 * compare/period match pulses come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "capseq_cfg.svh"

module capture_sequence_irq_ctl (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capture_pin,
   input wire logic compare_match,
   input wire logic period_match,
   output logic irq,
   output logic [1:0] event_index,
   output logic capture_load_en,
   output logic sequence_stopped
);
   // ************************************************************
   // Declarations
   // ************************************************************
   localparam capseq_pkg::top_regs_t TOP_RST = '{
      limit: `RST_LIMIT,
      single: `RST_SINGLE,
      irq_en: `RST_IRQ_EN,
      default: '0
   };

   capseq_pkg::top_regs_t r_ff;
   capseq_pkg::top_regs_t nxt_r;
   logic [31:0] rd;
   logic hit;
   logic cap_rise;
   logic ovf;
   logic arm;
   logic [7:0] clr;
   logic [7:0] frc;
   ctl_if u_if ();

   // Timestamp registers occupy four words from their base
   function automatic logic is_ts(input logic [11:0] a);
      is_ts = (a & `TS_BLOCK_MASK) == `OFF_TS0;
   endfunction : is_ts

   // ************************************************************
   // Sub-modules
   // ************************************************************
   capture_sequencer u_seq (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .s(u_if.seq)
   );

   flag_unit u_flg (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .f(u_if.flg)
   );

   // Hub side of the shared interface
   assign u_if.cap_event = cap_rise;
   assign u_if.arm = arm;
   assign u_if.single_mode = r_ff.single;
   assign u_if.pwm_mode = r_ff.pwm;
   assign u_if.limit = r_ff.limit;
   assign u_if.irq_en = r_ff.irq_en;
   assign u_if.clr = clr;
   assign u_if.frc = frc;
   // Compare and period flags only count in PWM mode; rollover in both
   assign u_if.ev_hi = {compare_match & r_ff.pwm, period_match & r_ff.pwm, ovf};

   // ************************************************************
   // Pin edge and timestamp counter
   // ************************************************************
   // Only the second synchroniser stage feeds the edge detector
   assign cap_rise = r_ff.sync2 & ~r_ff.pin_prev;
   // Rollover is flagged in the cycle the running counter holds all ones
   assign ovf = r_ff.run & (r_ff.counter == 32'hffffffff);

   // ************************************************************
   // APB answer
   // ************************************************************
   // Zero wait states; pready stalls only while ce is low
   assign pready = psel & penable & r_ff.ready & ce;
   assign pslverr = pready & r_ff.err;
   assign prdata = r_ff.prdata;

   // Block outputs
   assign irq = u_if.irq;
   assign event_index = u_if.idx;
   assign capture_load_en = u_if.load_en;
   assign sequence_stopped = u_if.stopped;

   // Register map, one aligned word each, unused upper bits read zero:
   //    0x000 capture control two: bit 0 single sequence, bits 2:1 limit,
   //          bit 3 arm (write-one pulse, reads zero), bit 4 counter run,
   //          bit 9 PWM mode
   //    0x004 interrupt enables in bits 7:1, bit 0 reserved
   //    0x008 event flags, read-only
   //    0x00c flag clear and 0x010 flag force, write-one pulses
   //    0x014 timestamp counter, read-only
   //    0x020 to 0x02c timestamp slots one to four, read-only
   // Any address outside these and 0x020 to 0x02f answers with pslverr and ignores the write;
   // decoding on the setup address keeps pready free of decode logic
   // Read image, decoded from the setup-phase address
   always_comb begin
      rd = 32'h0;
      hit = 1'b1;
      if (paddr == `OFF_CTL2) begin
         rd[`CTL2_SINGLE] = r_ff.single;
         rd[`CTL2_LIMIT_HI:`CTL2_LIMIT_LO] = r_ff.limit;
         rd[`CTL2_RUN] = r_ff.run;
         rd[`CTL2_PWM] = r_ff.pwm;
         rd[`CTL2_ARM] = 1'b0;
      end else if (paddr == `OFF_IRQ_EN) begin
         rd[7:0] = r_ff.irq_en;
      end else if (paddr == `OFF_FLAGS) begin
         rd[7:0] = u_if.flags;
      end else if (paddr == `OFF_CLEAR || paddr == `OFF_FORCE) begin
         rd = 32'h0;
      end else if (paddr == `OFF_COUNTER) begin
         rd = r_ff.counter;
      end else if (is_ts(paddr)) begin
         rd = r_ff.ts[paddr[3:2]];
      end else begin
         hit = 1'b0;
      end
   end

   // ************************************************************
   // Next state
   // ************************************************************
   // Writes land at the completing access edge; arm, clear and force
   // are one-cycle pulses so a written zero does nothing
   always_comb begin
      nxt_r = r_ff;
      arm = 1'b0;
      clr = 8'h00;
      frc = 8'h00;
      nxt_r.sync1 = capture_pin;
      nxt_r.sync2 = r_ff.sync1;
      nxt_r.pin_prev = r_ff.sync2;
      if (r_ff.run) begin
         nxt_r.counter = r_ff.counter + 32'h1;
      end
      // Load the timestamp of the event into the slot of its index
      if (u_if.load_strobe) begin
         nxt_r.ts[u_if.idx] = r_ff.counter;
      end
      if (psel && !penable) begin
         nxt_r.prdata = rd;
         nxt_r.err = ~hit;
         nxt_r.ready = 1'b1;
      end
      if (pready) begin
         nxt_r.ready = 1'b0;
         if (pwrite && !r_ff.err) begin
            if (paddr == `OFF_CTL2) begin
               nxt_r.single = pwdata[`CTL2_SINGLE];
               nxt_r.limit = pwdata[`CTL2_LIMIT_HI:`CTL2_LIMIT_LO];
               nxt_r.run = pwdata[`CTL2_RUN];
               nxt_r.pwm = pwdata[`CTL2_PWM];
               arm = pwdata[`CTL2_ARM];
            end else if (paddr == `OFF_IRQ_EN) begin
               nxt_r.irq_en = pwdata[7:0] & `IRQ_EN_MASK;
            end else if (paddr == `OFF_CLEAR) begin
               clr = pwdata[7:0];
            end else if (paddr == `OFF_FORCE) begin
               frc = pwdata[7:0];
            end
         end
      end
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Everything freezes with ce low, synchroniser included
   always_ff @(posedge clk) begin
      if (!resetn) begin
         r_ff <= TOP_RST;
      end else if (ce) begin
         r_ff <= nxt_r;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   a_arm_reads_zero: assert property (@(posedge clk) disable iff (!resetn)
      pready && !pwrite && !r_ff.err |-> !r_ff.prdata[`CTL2_ARM] || paddr != `OFF_CTL2)
      else $error("arm bit read back as one");
   a_rollover_flag: assert property (@(posedge clk) disable iff (!resetn)
      ce && r_ff.run && r_ff.counter == 32'hffffffff |=> u_if.flags[`FLG_OVF])
      else $error("rollover did not set its flag");
   a_ts_load: assert property (@(posedge clk) disable iff (!resetn)
      ce && u_if.load_strobe |=> r_ff.ts[$past(u_if.idx)] == $past(r_ff.counter))
      else $error("timestamp not loaded into indexed slot");
   a_enable_reserved: assert property (@(posedge clk) disable iff (!resetn)
      ce && pready && pwrite && paddr == `OFF_IRQ_EN |=> r_ff.irq_en[0] == 1'b0
         && r_ff.irq_en[7:1] == $past(pwdata[7:1]))
      else $error("enable register write wrong");
   a_flag_reg_ro: assert property (@(posedge clk) disable iff (!resetn)
      ce && pready && pwrite && paddr == `OFF_FLAGS && u_if.flags == 8'h00
         && u_if.ev_hi == 3'h0 && u_if.cevt == 4'h0 && u_if.irq_en == 8'h00 |=> u_if.flags == 8'h00)
      else $error("flag register changed by a write");

   // ************************************************************
   // Register write effects and flag routing
   // ************************************************************
   // These watch the hub's own decode and its paths into the sub-modules
   a_arm_zero_write: assert property (@(posedge clk) disable iff (!resetn)
      ce && pready && pwrite && paddr == `OFF_CTL2 && !pwdata[`CTL2_ARM]
         && u_if.stopped |=> u_if.stopped)
      else $error("written zero on arm restarted the sequence");
   a_arm_continuous: assert property (@(posedge clk) disable iff (!resetn)
      ce && arm && !r_ff.single
         |=> u_if.idx == 2'h0 && !u_if.stopped && u_if.load_en)
      else $error("arm failed in continuous mode");
   a_limit_write: assert property (@(posedge clk) disable iff (!resetn)
      pready && pwrite && !r_ff.err && paddr == `OFF_CTL2
         |=> r_ff.limit == $past(pwdata[`CTL2_LIMIT_HI:`CTL2_LIMIT_LO]))
      else $error("limit field not written");
   a_mode_write: assert property (@(posedge clk) disable iff (!resetn)
      pready && pwrite && !r_ff.err && paddr == `OFF_CTL2
         |=> r_ff.single == $past(pwdata[`CTL2_SINGLE]))
      else $error("mode bit not written");
   a_no_capture_stopped: assert property (@(posedge clk) disable iff (!resetn)
      ce && u_if.stopped && u_if.frc[4:1] == 4'h0
         |=> (u_if.flags[4:1] & ~$past(u_if.flags[4:1])) == 4'h0)
      else $error("capture flag set while stopped");
   a_cmp_flag: assert property (@(posedge clk) disable iff (!resetn)
      ce && r_ff.pwm && compare_match
         |=> u_if.flags[`FLG_CMP])
      else $error("compare match not flagged");
   a_prd_flag: assert property (@(posedge clk) disable iff (!resetn)
      ce && r_ff.pwm && period_match
         |=> u_if.flags[`FLG_PRD])
      else $error("period match not flagged");
   a_ovf_gate: assert property (@(posedge clk) disable iff (!resetn)
      ce && !u_if.irq && u_if.flags[`FLG_OVF] && r_ff.irq_en[`FLG_OVF]
         |=> u_if.irq)
      else $error("enabled rollover did not interrupt");
   a_enable_image: assert property (@(posedge clk) disable iff (!resetn)
      ce && psel && !penable && paddr == `OFF_IRQ_EN
         |=> !r_ff.prdata[0] && r_ff.prdata[31:8] == 24'h0)
      else $error("reserved enable bits read nonzero");
   a_flag_image: assert property (@(posedge clk) disable iff (!resetn)
      ce && psel && !penable && paddr == `OFF_FLAGS
         |=> r_ff.prdata == {24'h0, $past(u_if.flags)})
      else $error("flag register read image wrong");
   a_counter_wrap: assert property (@(posedge clk) disable iff (!resetn)
      ce && r_ff.run && r_ff.counter == 32'hffffffff
         |=> r_ff.counter == 32'h0)
      else $error("counter did not wrap to zero");
   a_pwm_ts_hold: assert property (@(posedge clk) disable iff (!resetn)
      ce && r_ff.pwm
         |=> r_ff.ts == $past(r_ff.ts))
      else $error("timestamp changed in PWM mode");
endmodule : capture_sequence_irq_ctl

`default_nettype wire

// file: bench/test_capture_sequence_irq_ctl.sv
/*
 * Self-checking bench for the capture sequencing and interrupt-enable block.
 * Drives the APB slave, the capture pin and the match pulses directly.
 * Assumes a 40 MHz clock and a synchronous, active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "capseq_cfg.svh"

module test_capture_sequence_irq_ctl;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic capture_pin = 1'b0;
   logic compare_match = 1'b0;
   logic period_match = 1'b0;
   logic irq;
   logic [1:0] event_index;
   logic capture_load_en;
   logic sequence_stopped;
   logic [31:0] rdata;
   logic rerr;
   logic [31:0] m;
   int fails = 0;
   int samples_checked = 0;

   // ************************************************************
   // Clock and device
   // ************************************************************
   always #12.5 clk = ~clk;

   capture_sequence_irq_ctl dut_u (
      .clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
      .compare_match(compare_match), .period_match(period_match), .irq(irq),
      .event_index(event_index), .capture_load_en(capture_load_en),
      .sequence_stopped(sequence_stopped)
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   task complete_run;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One APB transfer; waits on pready without assuming a latency
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 64) begin
         n++;
         @(posedge clk);
      end
      if (n >= 64) begin
         check({31'h0, pready}, 32'h1);
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdata, exp);
      check({31'h0, rerr}, 32'h0);
   endtask : rd_chk

   // Outputs are looked at on the falling edge, well after the updates land
   task settle;
      repeat (3) @(negedge clk);
   endtask : settle

   task port_chk(input logic [1:0] idx, input logic st, input logic ld);
      check({28'h0, event_index, sequence_stopped, capture_load_en}, {28'h0, idx, st, ld});
   endtask : port_chk

   // Pin held high and low long enough to pass the two-stage synchroniser
   task pin_pulse;
      @(posedge clk);
      capture_pin <= 1'b1;
      repeat (3) @(posedge clk);
      capture_pin <= 1'b0;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask : pin_pulse

   task match_pulse(input logic cmp);
      @(posedge clk);
      compare_match <= cmp;
      period_match <= ~cmp;
      @(posedge clk);
      compare_match <= 1'b0;
      period_match <= 1'b0;
      settle;
   endtask : match_pulse

   // ************************************************************
   // Watchdog: the whole sequence needs under a thousand cycles
   // ************************************************************
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      complete_run;
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      settle;
      port_chk(2'd0, 1'b0, 1'b1);
      rd_chk(`OFF_CTL2, 32'h6);
      rd_chk(`OFF_IRQ_EN, 32'h0);
      rd_chk(`OFF_FLAGS, 32'h0);
      apb(1'b1, `OFF_FLAGS, 32'hff);
      rd_chk(`OFF_FLAGS, 32'h0);
      rd_chk(`OFF_CLEAR, 32'h0);
      apb(1'b0, 12'h018, 32'h0);
      check({31'h0, rerr}, 32'h1);
      apb(1'b1, `OFF_IRQ_EN, 32'hffff);
      rd_chk(`OFF_IRQ_EN, 32'hfe);
      apb(1'b1, `OFF_IRQ_EN, 32'h0);

      // Every limit code in both modes; one event past the limit each time
      for (int sg = 0; sg < 2; sg++) begin
         for (int lim = 0; lim < 4; lim++) begin
            m = ((32'h1 << (lim + 1)) - 32'h1) << 1;
            apb(1'b1, `OFF_CLEAR, 32'hff);
            apb(1'b1, `OFF_CTL2, sg | (lim << 1) | 8);
            settle;
            port_chk(2'd0, 1'b0, 1'b1);
            repeat (lim + 2) pin_pulse;
            rd_chk(`OFF_FLAGS, m);
            if (sg == 1) begin
               check({30'h0, sequence_stopped, capture_load_en}, 32'h2);
            end else begin
               port_chk((lim == 0) ? 2'd0 : 2'd1, 1'b0, 1'b1);
            end
            rd_chk(`OFF_CTL2, sg | (lim << 1));
         end
      end
      // Writing zero to the arm bit leaves the sequence frozen
      apb(1'b1, `OFF_CTL2, 32'h7);
      settle;
      check({31'h0, sequence_stopped}, 32'h1);

      // Two captures nine clocks apart land in neighbouring slots
      apb(1'b1, `OFF_CTL2, 32'h1e);
      repeat (2) pin_pulse;
      apb(1'b0, `OFF_TS0, 32'h0);
      m = rdata;
      apb(1'b0, `OFF_TS0 + 12'h004, 32'h0);
      check(rdata - m, 32'h9);
      // Twenty frozen clocks between two counter reads leave four ticks
      apb(1'b0, `OFF_COUNTER, 32'h0);
      m = rdata;
      @(posedge clk);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      apb(1'b0, `OFF_COUNTER, 32'h0);
      check(rdata - m, 32'h4);

      // Configure with unit interrupts off, clear stale flags, then enable
      apb(1'b1, `OFF_CTL2, 32'he);
      apb(1'b1, `OFF_CLEAR, 32'hff);
      apb(1'b1, `OFF_IRQ_EN, 32'h2);
      pin_pulse;
      settle;
      check({31'h0, irq}, 32'h1);
      rd_chk(`OFF_FLAGS, 32'h3);
      apb(1'b1, `OFF_CLEAR, 32'h1);
      settle;
      check({31'h0, irq}, 32'h1);
      apb(1'b1, `OFF_CLEAR, 32'h3);
      settle;
      check({31'h0, irq}, 32'h0);
      pin_pulse;
      settle;
      check({31'h0, irq}, 32'h0);
      rd_chk(`OFF_FLAGS, 32'h4);

      // Each event flag, bits 7:1, forced with its enable off, then on
      for (int b = 1; b < 8; b++) begin
         apb(1'b1, `OFF_IRQ_EN, 32'h0);
         apb(1'b1, `OFF_CLEAR, 32'hff);
         apb(1'b1, `OFF_FORCE, 32'h1 << b);
         settle;
         check({31'h0, irq}, 32'h0);
         rd_chk(`OFF_FLAGS, 32'h1 << b);
         apb(1'b1, `OFF_CLEAR, 32'h1 << b);
         rd_chk(`OFF_FLAGS, 32'h0);
         apb(1'b1, `OFF_IRQ_EN, 32'h1 << b);
         apb(1'b1, `OFF_FORCE, 32'h1 << b);
         settle;
         check({31'h0, irq}, 32'h1);
      end

      // Auxiliary PWM mode: pin ignored, match pulses flagged
      apb(1'b1, `OFF_IRQ_EN, 32'h0);
      apb(1'b1, `OFF_CLEAR, 32'hff);
      apb(1'b1, `OFF_CTL2, 32'h208);
      pin_pulse;
      rd_chk(`OFF_FLAGS, 32'h0);
      match_pulse(1'b1);
      rd_chk(`OFF_FLAGS, 32'h80);
      match_pulse(1'b0);
      rd_chk(`OFF_FLAGS, 32'hc0);
      check({31'h0, irq}, 32'h0);
      complete_run;
   end
endmodule : test_capture_sequence_irq_ctl

`default_nettype wire
